// file: shared/svcil_pkg.sv
// package: constants, register map and carrier types of the servo command input logic
`default_nettype none
package svcil_pkg;
  // clocking and contact filtering
  localparam int unsigned CLK_MHZ     = 200;
  localparam int unsigned DEB_TIME_US = 1000;
  localparam int unsigned DEB_CYCLES  = DEB_TIME_US * CLK_MHZ;

  // register byte offsets, presets occupy 7 words from OFS_PRESET
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_ENC_DIV    = 8'h04;
  localparam logic [7:0] OFS_TRQ_FWD    = 8'h08;
  localparam logic [7:0] OFS_TRQ_REV    = 8'h0C;
  localparam logic [7:0] OFS_TRQ_FS     = 8'h10;
  localparam logic [7:0] OFS_MAX_SPD    = 8'h14;
  localparam logic [7:0] OFS_PRESET     = 8'h18;
  localparam logic [7:0] OFS_PRESET_END = 8'h34;
  localparam logic [7:0] OFS_STATUS     = 8'h34;
  localparam logic [7:0] OFS_POS_ERR    = 8'h38;
  localparam int unsigned N_PRESET      = 7;

  // control word fields
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_STOP_BIT = 2;
  localparam int unsigned CTRL_HALT_BIT = 3;
  localparam int unsigned CTRL_PFMT_LSB = 4;

  // reset values and scaling
  localparam logic        STOP_INV_RST  = 1'b0;
  localparam logic        HALT_FORM_RST = 1'b0;
  localparam logic [15:0] ENC_DIV_RST   = 16'h0001;
  localparam logic [15:0] TRQ_RST       = 16'h7FFF;
  localparam logic [15:0] SPD_RST       = 16'h7FFF;
  localparam int unsigned ANA_SHIFT     = 15;

  typedef enum logic [1:0] {
    MODE_SPEED    = 2'b00,
    MODE_POSITION = 2'b01,
    MODE_TORQUE   = 2'b10
  } svcil_mode_type;

  typedef enum logic [1:0] {
    PF_DIR_PULSE = 2'b00,
    PF_FWD_REV   = 2'b01,
    PF_QUAD      = 2'b10
  } svcil_pfmt_type;

  typedef enum logic [1:0] {
    ST_OFF   = 2'b00,
    ST_RUN   = 2'b01,
    ST_DECEL = 2'b10,
    ST_FAULT = 2'b11
  } svcil_state_type;

  typedef struct packed {
    logic servo_enable_in;
    logic select_bit2_in;
    logic select_bit1_in;
    logic select_bit0_in;
    logic dir_reverse_in;
    logic fwd_travel_limit_in;
    logic rev_travel_limit_in;
    logic analog_torque_limit_sel;
    logic alarm_clear_in;
    logic emergency_halt_in;
    logic loop_type_sel;
    logic stop_start_in;
  } svcil_contacts_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } svcil_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } svcil_apb_rsp_type;

  typedef struct packed {
    logic               drive_on;
    logic               hold_torque;
    logic               fast_decel;
    logic               ext_alarm;
    logic               p_only;
    logic               fwd_inhibit;
    logic               rev_inhibit;
    logic [1:0]         gear_sel;
    logic [1:0]         limit_sel;
    logic signed [15:0] speed_cmd;
    logic [15:0]        speed_limit;
    logic signed [15:0] torque_cmd;
    logic [15:0]        analog_torque_limit_sel_fwd;
    logic [15:0]        analog_torque_limit_sel_rev;
  } svcil_drive_cmd_type;

  typedef struct packed {
    logic enc_out_a;
    logic enc_out_a_n;
    logic enc_out_b;
    logic enc_out_b_n;
    logic enc_out_z;
    logic enc_out_z_n;
  } svcil_enc_out_type;
endpackage : svcil_pkg
`default_nettype wire

// file: logic/svcil_debounce.sv
// contact synchroniser and debounce filter
`timescale 1ns/1ps
`default_nettype none
module svcil_debounce #(
  parameter int unsigned W   = 12,
  parameter int unsigned CNT = 200000
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] raw_in,
  output logic      [W-1:0] clean_out,
  output logic              valid_out
);
  localparam int unsigned CW = $clog2(CNT + 1);

  typedef struct packed {
    logic [W-1:0]  s1;
    logic [W-1:0]  s2;
    logic [W-1:0]  last;
    logic [W-1:0]  clean;
    logic [CW-1:0] cnt;
    logic          valid;
  } svcil_deb_state_type;

  svcil_deb_state_type r;
  svcil_deb_state_type n;

  // whole vector must stay still for CNT cycles; one counter instead of one per contact
  always_comb begin
    n = r;
    n.s1 = raw_in;
    n.s2 = r.s1;
    n.last = r.s2;
    if (r.s2 != r.last) begin
      n.cnt = '0;
    end else if (r.cnt == CW'(CNT - 1)) begin
      n.clean = r.s2;
      n.valid = 1'b1;
    end else begin
      n.cnt = r.cnt + CW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign clean_out = r.clean;
  assign valid_out = r.valid;
endmodule : svcil_debounce
`default_nettype wire

// file: logic/svcil_top.sv
// control-connector command input logic of the servo drive with its apb register file
`timescale 1ns/1ps
`default_nettype none
// How it works
// [R01] drive is enabled only while servo enable contact is on, any mode
// [R02] enable releases power stage and braking, then speed select rules apply
// [R03] speed mode: three select bits pick analog (0) or preset 1..7
// [R04] direction contact on inverts commanded speed, analog included
// [R05] controller keeps direction contact off with an upper position loop
// [R06] alarm clear drops the alarm and, in position mode, the pulse error
// [R07] controller drops servo enable before requesting alarm clear
// [R08] stop forces speed command to zero and holds stopping torque; code raises hold_torque in speed mode only
// [R09] stop contact sense is selectable in the control register
// [R10] halt raises alarm, overrides inputs, decelerates fast, then drive off
// [R11] halt contact form is selectable in the control register
// [R12] travel limit off means active; it blocks motion that way
// [R13] torque limit select on: analog limit; off: stored fwd/rev limits
// [R14] analog limit scales by magnitude, full input gives full-scale torque
// [R15] analog speed maps linearly, full scale gives max speed each way
// [R16] loop type contact on gives P-only, off gives PI speed loop
// [R17] controller uses loop type only for long zero-speed holding
// [R18] command pulses: dir+pulse, fwd/rev trains or quadrature, selectable
// [R19] motor encoder divided by a ratio and sent out as A/B/Z pairs
// [R20] first two select bits: gear in position, limit select in torque
// [R21] analog inputs change meaning with speed, position and torque modes
// [R22] every contact is synchronised and debounced before use
module svcil_top #(
  parameter int unsigned DEB_CYCLES = svcil_pkg::DEB_CYCLES
) (
  input  wire logic                           pclk,
  input  wire logic                           presetn,
  input  wire svcil_pkg::svcil_apb_req_type   apb_req,
  output var  svcil_pkg::svcil_apb_rsp_type   apb_rsp,
  input  wire svcil_pkg::svcil_contacts_type  contacts_in,
  input  wire logic                           fwd_cmd_pulse_in,
  input  wire logic                           rev_cmd_pulse_in,
  input  wire logic signed [15:0]             analog_speed_in,
  input  wire logic signed [15:0]             analog_torque_in,
  input  wire logic                           mot_enc_a,
  input  wire logic                           mot_enc_b,
  input  wire logic                           mot_enc_z,
  input  wire logic                           drive_fault_in,
  input  wire logic                           zero_speed_in,
  output var  svcil_pkg::svcil_drive_cmd_type drive_cmd,
  output var  svcil_pkg::svcil_enc_out_type   enc_out,
  output logic signed [31:0]                  pos_error
);
  localparam int unsigned NP = svcil_pkg::N_PRESET;

  typedef struct packed {
    svcil_pkg::svcil_state_type     st;
    logic [1:0]                     mode;
    logic                           stop_inv;
    logic                           halt_form;
    logic [1:0]                     pfmt;
    logic [15:0]                    enc_div;
    logic [15:0]                    trq_fwd;
    logic [15:0]                    trq_rev;
    logic [15:0]                    trq_fs;
    logic [15:0]                    max_spd;
    logic [NP-1:0][15:0]            preset;
    logic [31:0]                    prdata;
    logic                           pslverr;
    logic                           alarm;
    logic signed [31:0]             pos_err;
    logic [1:0]                     cmd_prev;
    logic [1:0]                     fb_prev;
    logic signed [16:0]             div_acc;
    logic [1:0]                     out_ph;
    svcil_pkg::svcil_enc_out_type   enc;
    svcil_pkg::svcil_drive_cmd_type cmd;
  } svcil_top_state_type;

  svcil_top_state_type           r;
  svcil_top_state_type           n;
  svcil_pkg::svcil_contacts_type c;
  logic                          c_valid;

  // gray position of an a/b pair: 00,01,11,10 counts upward
  function automatic logic [1:0] quad_pos(input logic [1:0] ab);
    return {ab[1], ab[1] ^ ab[0]};
  endfunction : quad_pos

  // one quadrature step, a double jump is dropped as illegal
  function automatic logic signed [1:0] quad_step(input logic [1:0] prev,
                                                  input logic [1:0] cur);
    logic [1:0] d;
    d = quad_pos(cur) - quad_pos(prev);
    case (d)
      2'h1:    return 2'sh1;
      2'h3:    return 2'sh3;
      default: return 2'sh0;
    endcase
  endfunction : quad_step

  // signed input times a 15-bit full-scale value, full input is 2^15
  function automatic logic signed [15:0] scale_s(input logic signed [15:0] a,
                                                 input logic [14:0] k);
    logic signed [31:0] p;
    p = a * $signed({1'b0, k});
    return p[svcil_pkg::ANA_SHIFT +: 16];
  endfunction : scale_s

  // magnitude times a 16-bit full-scale value
  function automatic logic [15:0] scale_m(input logic [15:0] m,
                                          input logic [15:0] k);
    logic [31:0] p;
    p = m * k;
    return p[svcil_pkg::ANA_SHIFT +: 16];
  endfunction : scale_m

  function automatic logic [15:0] abs16(input logic signed [15:0] a);
    return a[15] ? 16'(-a) : a;
  endfunction : abs16

  // saturating negate so the most negative preset cannot wrap
  function automatic logic signed [15:0] neg_sat(input logic signed [15:0] a);
    return (a == 16'sh8000) ? 16'sh7FFF : -a;
  endfunction : neg_sat

  // aligned word; status and error words are read-only
  function automatic logic addr_ok(input logic [7:0] a, input logic wr);
    return (a[1:0] == 2'h0) &&
           ((a < svcil_pkg::OFS_PRESET_END) || (!wr && a <= svcil_pkg::OFS_POS_ERR));
  endfunction : addr_ok

  function automatic logic [2:0] preset_idx(input logic [7:0] a);
    logic [7:0] t;
    t = a - svcil_pkg::OFS_PRESET;
    return t[4:2];
  endfunction : preset_idx

  // contacts pass two flops and a stability filter
  svcil_debounce #(
    .W   ($bits(svcil_pkg::svcil_contacts_type)),
    .CNT (DEB_CYCLES)
  ) u_debounce (
    .pclk      (pclk),
    .presetn   (presetn),
    .raw_in    (contacts_in),
    .clean_out (c),
    .valid_out (c_valid)
  ); // R22

  // next-state logic: bus slave, sequencing, command shaping, pulse and encoder paths
  always_comb begin
    logic               setup;
    logic               wr;
    logic               halt;
    logic               stop;
    logic               fault;
    logic               run;
    logic               drv;
    logic               use_ana;
    logic               is_spd;
    logic               is_pos;
    logic               is_trq;
    logic [2:0]         sel;
    logic [15:0]        tq_mag;
    logic [15:0]        dv;
    logic signed [15:0] spd;
    logic signed [15:0] tqc;
    logic signed [1:0]  cstep;
    logic signed [1:0]  fstep;
    logic signed [16:0] acc;
    logic [1:0]         cur;
    logic [31:0]        rd;
    setup = 1'b0;
    wr = 1'b0;
    halt = 1'b0;
    stop = 1'b0;
    fault = 1'b0;
    run = 1'b0;
    drv = 1'b0;
    use_ana = 1'b0;
    is_spd = 1'b0;
    is_pos = 1'b0;
    is_trq = 1'b0;
    sel = 3'h0;
    tq_mag = 16'h0000;
    dv = 16'h0001;
    spd = 16'sh0000;
    tqc = 16'sh0000;
    cstep = 2'sh0;
    fstep = 2'sh0;
    acc = 17'sh00000;
    cur = 2'h0;
    rd = 32'h0000_0000;
    n = r;

    // apb: read data and error latched in setup, writes land at the access edge
    setup = apb_req.psel & ~apb_req.penable;
    wr = apb_req.psel & apb_req.penable & apb_req.pwrite;
    if (setup) begin
      case (apb_req.paddr)
        svcil_pkg::OFS_CTRL: begin
          rd[svcil_pkg::CTRL_MODE_LSB +: 2] = r.mode;
          rd[svcil_pkg::CTRL_STOP_BIT] = r.stop_inv;
          rd[svcil_pkg::CTRL_HALT_BIT] = r.halt_form;
          rd[svcil_pkg::CTRL_PFMT_LSB +: 2] = r.pfmt;
        end
        svcil_pkg::OFS_ENC_DIV: rd = {16'h0000, r.enc_div};
        svcil_pkg::OFS_TRQ_FWD: rd = {16'h0000, r.trq_fwd};
        svcil_pkg::OFS_TRQ_REV: rd = {16'h0000, r.trq_rev};
        svcil_pkg::OFS_TRQ_FS:  rd = {16'h0000, r.trq_fs};
        svcil_pkg::OFS_MAX_SPD: rd = {16'h0000, r.max_spd};
        svcil_pkg::OFS_STATUS: begin
          rd = {13'h0000, r.st, r.alarm, r.cmd.drive_on, r.cmd.fwd_inhibit,
                r.cmd.rev_inhibit, c_valid, c};
        end
        svcil_pkg::OFS_POS_ERR: rd = r.pos_err;
        default: begin
          if (addr_ok(apb_req.paddr, 1'b1) && apb_req.paddr >= svcil_pkg::OFS_PRESET) begin
            rd = {16'h0000, r.preset[preset_idx(apb_req.paddr)]};
          end
        end
      endcase
      n.prdata = rd;
      n.pslverr = ~addr_ok(apb_req.paddr, apb_req.pwrite);
    end
    if (wr && addr_ok(apb_req.paddr, 1'b1)) begin
      case (apb_req.paddr)
        svcil_pkg::OFS_CTRL: begin
          n.mode = apb_req.pwdata[svcil_pkg::CTRL_MODE_LSB +: 2];
          n.stop_inv = apb_req.pwdata[svcil_pkg::CTRL_STOP_BIT]; // R09
          n.halt_form = apb_req.pwdata[svcil_pkg::CTRL_HALT_BIT]; // R11
          n.pfmt = apb_req.pwdata[svcil_pkg::CTRL_PFMT_LSB +: 2]; // R18
        end
        svcil_pkg::OFS_ENC_DIV: n.enc_div = apb_req.pwdata[15:0];
        svcil_pkg::OFS_TRQ_FWD: n.trq_fwd = apb_req.pwdata[15:0];
        svcil_pkg::OFS_TRQ_REV: n.trq_rev = apb_req.pwdata[15:0];
        svcil_pkg::OFS_TRQ_FS:  n.trq_fs = apb_req.pwdata[15:0];
        svcil_pkg::OFS_MAX_SPD: n.max_spd = apb_req.pwdata[15:0];
        default: n.preset[preset_idx(apb_req.paddr)] = apb_req.pwdata[15:0];
      endcase
    end

    // mode 2'b11 is unused and behaves as speed mode
    is_pos = (r.mode == svcil_pkg::MODE_POSITION);
    is_trq = (r.mode == svcil_pkg::MODE_TORQUE);
    is_spd = ~is_pos & ~is_trq;

    // halt form 0 is a break contact: held on in normal work, off means halt
    halt = c_valid & (r.halt_form ? c.emergency_halt_in : ~c.emergency_halt_in); // R11
    stop = c_valid & (c.stop_start_in ^ r.stop_inv); // R09
    fault = drive_fault_in | halt;

    // alarm latch: a fault in the clearing cycle keeps the alarm
    if (fault) begin
      n.alarm = 1'b1; // R10
    end else if (c_valid && c.alarm_clear_in) begin
      n.alarm = 1'b0; // R06
    end

    // sequencing; nothing starts before the contact filter has settled
    case (r.st)
      svcil_pkg::ST_OFF: begin
        if (fault || r.alarm) begin
          n.st = svcil_pkg::ST_FAULT;
        end else if (c_valid && c.servo_enable_in) begin
          n.st = svcil_pkg::ST_RUN;
        end
      end
      svcil_pkg::ST_RUN: begin
        if (halt) begin
          n.st = svcil_pkg::ST_DECEL; // R10
        end else if (fault || r.alarm) begin
          n.st = svcil_pkg::ST_FAULT;
        end else if (!c.servo_enable_in) begin
          n.st = svcil_pkg::ST_OFF;
        end
      end
      svcil_pkg::ST_DECEL: begin
        // other contacts are ignored here until standstill
        if (zero_speed_in) begin
          n.st = svcil_pkg::ST_FAULT; // R10
        end
      end
      svcil_pkg::ST_FAULT: begin
        if (!r.alarm && !fault) begin
          n.st = svcil_pkg::ST_OFF;
        end
      end
      default: n.st = svcil_pkg::ST_OFF;
    endcase
    run = (r.st == svcil_pkg::ST_RUN);
    // the enable contact gates the power stage in every state
    drv = (run | (r.st == svcil_pkg::ST_DECEL)) & c_valid & c.servo_enable_in; // R01 R02

    // speed command: select 0 takes the analog input, 1..7 a preset
    sel = {c.select_bit2_in, c.select_bit1_in, c.select_bit0_in};
    if (is_spd) begin
      if (sel == 3'h0) begin
        spd = scale_s(analog_speed_in, r.max_spd[14:0]); // R15 R21
      end else begin
        spd = r.preset[3'(sel - 3'h1)]; // R03
      end
      if (c.dir_reverse_in) begin
        spd = neg_sat(spd); // R04
      end
    end
    if (stop || !run) begin
      spd = 16'sh0000; // R08
    end

    // travel limits are break contacts; off blocks that direction
    n.cmd.fwd_inhibit = ~c.fwd_travel_limit_in; // R12
    n.cmd.rev_inhibit = ~c.rev_travel_limit_in; // R12
    if ((n.cmd.fwd_inhibit && spd > 16'sh0000) || (n.cmd.rev_inhibit && spd < 16'sh0000)) begin
      spd = 16'sh0000; // R12
    end

    // torque: analog limit outside torque mode, command inside it
    tq_mag = scale_m(abs16(analog_torque_in), r.trq_fs); // R14
    use_ana = c.analog_torque_limit_sel & ~is_trq; // R13 R21
    if (is_trq && drv) begin
      tqc = scale_s(analog_torque_in, r.trq_fs[14:0]); // R21
    end
    if ((n.cmd.fwd_inhibit && tqc > 16'sh0000) || (n.cmd.rev_inhibit && tqc < 16'sh0000)) begin
      tqc = 16'sh0000; // R12
    end

    n.cmd.drive_on = drv; // R01 R02
    n.cmd.hold_torque = run & stop & is_spd; // R08
    n.cmd.fast_decel = (r.st == svcil_pkg::ST_DECEL); // R10
    n.cmd.ext_alarm = n.alarm; // R10
    n.cmd.p_only = c.loop_type_sel & ~is_trq; // R16
    n.cmd.gear_sel = is_pos ? sel[1:0] : 2'h0; // R20
    n.cmd.limit_sel = is_trq ? sel[1:0] : 2'h0; // R20
    n.cmd.speed_cmd = spd;
    n.cmd.torque_cmd = tqc;
    n.cmd.analog_torque_limit_sel_fwd = use_ana ? tq_mag : r.trq_fwd; // R13
    n.cmd.analog_torque_limit_sel_rev = use_ana ? tq_mag : r.trq_rev; // R13
    n.cmd.speed_limit = is_trq ? scale_m(abs16(analog_speed_in), {1'b0, r.max_spd[14:0]})
                               : 16'h0000; // R21

    // command pulse decode in the selected format
    cur = {fwd_cmd_pulse_in, rev_cmd_pulse_in};
    n.cmd_prev = cur;
    case (r.pfmt)
      svcil_pkg::PF_DIR_PULSE: begin
        if (cur[1] && !r.cmd_prev[1]) begin
          cstep = cur[0] ? 2'sh3 : 2'sh1; // R18
        end
      end
      svcil_pkg::PF_FWD_REV: begin
        if (cur[1] && !r.cmd_prev[1] && !(cur[0] && !r.cmd_prev[0])) begin
          cstep = 2'sh1; // R18
        end else if (cur[0] && !r.cmd_prev[0] && !(cur[1] && !r.cmd_prev[1])) begin
          cstep = 2'sh3; // R18
        end
      end
      svcil_pkg::PF_QUAD: cstep = quad_step(r.cmd_prev, cur); // R18
      default: cstep = 2'sh0;
    endcase

    // feedback steps from the motor encoder
    n.fb_prev = {mot_enc_a, mot_enc_b};
    fstep = quad_step(r.fb_prev, n.fb_prev);

    // following error; a clear reloads this cycle's steps so none are lost
    if (is_pos && c_valid && c.alarm_clear_in) begin
      n.pos_err = 32'(cstep) - 32'(fstep); // R06
    end else if (is_pos && drv) begin
      n.pos_err = r.pos_err + 32'(cstep) - 32'(fstep);
    end

    // encoder divider: one output edge per dv motor edges, ratio 0 acts as 1
    dv = (r.enc_div == 16'h0000) ? 16'h0001 : r.enc_div;
    acc = r.div_acc + 17'(fstep);
    if (acc >= $signed({1'b0, dv})) begin
      acc = acc - $signed({1'b0, dv}); // R19
      n.out_ph = r.out_ph + 2'h1;
    end else if (acc <= -$signed({1'b0, dv})) begin
      acc = acc + $signed({1'b0, dv}); // R19
      n.out_ph = r.out_ph - 2'h1;
    end
    n.div_acc = acc;
    n.enc.enc_out_a = n.out_ph[1]; // R19
    n.enc.enc_out_a_n = ~n.out_ph[1];
    n.enc.enc_out_b = n.out_ph[1] ^ n.out_ph[0];
    n.enc.enc_out_b_n = ~(n.out_ph[1] ^ n.out_ph[0]);
    n.enc.enc_out_z = mot_enc_z;
    n.enc.enc_out_z_n = ~mot_enc_z;
  end

  // state register; differential complements idle high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.stop_inv <= svcil_pkg::STOP_INV_RST;
      r.halt_form <= svcil_pkg::HALT_FORM_RST;
      r.enc_div <= svcil_pkg::ENC_DIV_RST;
      r.trq_fwd <= svcil_pkg::TRQ_RST;
      r.trq_rev <= svcil_pkg::TRQ_RST;
      r.trq_fs <= svcil_pkg::TRQ_RST;
      r.max_spd <= svcil_pkg::SPD_RST;
      r.enc.enc_out_a_n <= 1'b1;
      r.enc.enc_out_b_n <= 1'b1;
      r.enc.enc_out_z_n <= 1'b1;
      r.cmd.fwd_inhibit <= 1'b1;
      r.cmd.rev_inhibit <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // zero-wait slave: every access completes in its first access cycle
  assign apb_rsp = '{prdata: r.prdata, pready: 1'b1, pslverr: r.pslverr};
  assign drive_cmd = r.cmd;
  assign enc_out = r.enc;
  assign pos_error = r.pos_err;
endmodule : svcil_top
`default_nettype wire

// file: bench/svcil_props.sv
// concurrent checks on the ports of the servo command input logic
`timescale 1ns/1ps
`default_nettype none
module svcil_props (
  input wire logic                           pclk,
  input wire logic                           presetn,
  input wire svcil_pkg::svcil_apb_req_type   apb_req,
  input wire svcil_pkg::svcil_apb_rsp_type   apb_rsp,
  input wire svcil_pkg::svcil_contacts_type  contacts_in,
  input wire logic                           mot_enc_z,
  input wire logic                           zero_speed_in,
  input wire svcil_pkg::svcil_drive_cmd_type drive_cmd,
  input wire svcil_pkg::svcil_enc_out_type   enc_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // halt then standstill must end in a dead power stage
  sequence s_halt_still;
    drive_cmd.fast_decel && zero_speed_in;
  endsequence
  sequence s_drive_dead;
    ##[1:3] !drive_cmd.drive_on;
  endsequence
  a_ready_always: assert property (apb_rsp.pready) else $error("pready low");
  a_bad_addr: assert property (apb_req.psel && !apb_req.penable && apb_req.paddr > 8'h38
    |=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0) else $error("bad address accepted");
  a_pair_compl: assert property (enc_out.enc_out_a_n != enc_out.enc_out_a
    && enc_out.enc_out_b_n != enc_out.enc_out_b) else $error("encoder pair");
  a_index_delay: assert property ($past(presetn, 2)
    |-> enc_out.enc_out_z == $past(mot_enc_z)) else $error("index lag");
  a_enable_first: assert property ($rose(drive_cmd.drive_on)
    |-> $past(contacts_in.servo_enable_in, 6)) else $error("drive without enable");
  a_stop_zero: assert property (drive_cmd.hold_torque
    |-> drive_cmd.speed_cmd == 16'h0) else $error("stop speed");
  a_halt_alarm: assert property (drive_cmd.fast_decel
    |-> drive_cmd.ext_alarm && drive_cmd.speed_cmd == 16'h0) else $error("halt");
  a_halt_off: assert property (s_halt_still |-> s_drive_dead) else $error("halt end");
  a_fwd_block: assert property (drive_cmd.fwd_inhibit
    |-> drive_cmd.speed_cmd[15] || drive_cmd.speed_cmd == 16'h0) else $error("fwd");
  a_rev_block: assert property (drive_cmd.rev_inhibit
    |-> !drive_cmd.speed_cmd[15]) else $error("rev limit");
endmodule : svcil_props
bind svcil_top svcil_props u_props (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .contacts_in(contacts_in), .mot_enc_z(mot_enc_z),
  .zero_speed_in(zero_speed_in), .drive_cmd(drive_cmd), .enc_out(enc_out));
`default_nettype wire

// file: bench/svcil_cmd_source.sv
// upper controller model: a burst of four command steps in a chosen pulse format
`timescale 1ns/1ps
`default_nettype none
module svcil_cmd_source (
  input wire logic       pclk,
  input wire logic       go,
  input wire logic [1:0] fmt,
  input wire logic       dir,
  output logic           fwd,
  output logic           rev,
  output logic           busy
);
  logic [3:0] cnt = 4'h0;
  logic [1:0] q;
  initial busy = 1'b0;
  // sixteen cycles per burst, one step every four
  always @(posedge pclk) begin
    if (go && !busy) busy <= 1'b1;
    else if (busy) begin
      cnt <= cnt + 4'h1;
      if (cnt == 4'hF) busy <= 1'b0;
    end
  end
  // quadrature returns to 00 after the burst, which is the fourth step
  assign q = busy ? (dir ? 2'b00 - cnt[3:2] : cnt[3:2]) : 2'b00;
  assign fwd = fmt == 2'b10 ? q[1] : busy && cnt[1] && !(fmt == 2'b01 && dir);
  assign rev = fmt == 2'b10 ? q[1] ^ q[0] : fmt == 2'b00 ? dir : busy && cnt[1] && dir;
endmodule : svcil_cmd_source
`default_nettype wire

// file: bench/svcil_top_tb.sv
// self-checking bench of the servo command input logic
`timescale 1ns/1ps
`default_nettype none
module svcil_top_tb;
  localparam int unsigned DEB = 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic zs = 1'b0;
  logic zz = 1'b0;
  logic go = 1'b0;
  logic dir = 1'b0;
  logic [1:0] fmt = 2'b00;
  logic pf, pr, busy, err;
  logic [31:0] rd;
  logic signed [15:0] spd = 16'h0;
  logic signed [15:0] trq = 16'h0;
  logic signed [31:0] perr;
  svcil_pkg::svcil_apb_req_type req = '0;
  svcil_pkg::svcil_apb_rsp_type rsp;
  svcil_pkg::svcil_contacts_type con = 12'h064;
  svcil_pkg::svcil_drive_cmd_type cmd;
  int fail_count = 0;
  int samples_checked = 0;
  always #2.5 pclk = ~pclk;
  // toggling index keeps the z path busy
  always @(posedge pclk) zz <= ~zz;
  svcil_top #(.DEB_CYCLES(DEB)) u_dut (.pclk(pclk), .presetn(presetn), .apb_req(req),
    .apb_rsp(rsp), .contacts_in(con), .fwd_cmd_pulse_in(pf), .rev_cmd_pulse_in(pr),
    .analog_speed_in(spd), .analog_torque_in(trq), .mot_enc_a(1'b0), .mot_enc_b(1'b0),
    .mot_enc_z(zz), .drive_fault_in(1'b0), .zero_speed_in(zs), .drive_cmd(cmd),
    .enc_out(), .pos_error(perr));
  svcil_cmd_source u_src (.pclk(pclk), .go(go), .fmt(fmt), .dir(dir), .fwd(pf), .rev(pr),
    .busy(busy));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    if (n >= 50) begin
      fail_count++;
      finish_test;
    end
  endtask : apb
  // outputs are read at the falling edge, once settled
  task automatic hold(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : hold
  task automatic drive(input logic [11:0] v);
    @(posedge pclk);
    con <= v;
    hold(DEB + 8);
  endtask : drive
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      check(rd, i == 0 ? 32'h0 : i == 1 ? 32'h1 : 32'h7FFF);
    end
    apb(1'b0, 8'h3C, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, svcil_pkg::OFS_MAX_SPD, 32'h4000);
    apb(1'b1, svcil_pkg::OFS_TRQ_FS, 32'h4000);
    apb(1'b1, svcil_pkg::OFS_TRQ_FWD, 32'h1111);
    spd <= 16'sh2000;
    trq <= -16'sh4000;
    drive(12'h864);
    check(cmd.drive_on, 32'h1);
    check(cmd.speed_cmd, 32'h1000);
    check(cmd.analog_torque_limit_sel_fwd, 32'h1111);
    check(cmd.p_only, 32'h0);
    drive(12'h8F6);
    check({16'h0, cmd.speed_cmd}, 32'hF000);
    check(cmd.analog_torque_limit_sel_rev, 32'h2000);
    check(cmd.p_only, 32'h1);
    drive(12'h8F7);
    check(cmd.hold_torque, 32'h1);
    apb(1'b1, svcil_pkg::OFS_CTRL, 32'h4);
    hold(3);
    check({16'h0, cmd.speed_cmd}, 32'hF000);
    drive(12'h8D7);
    check(cmd.rev_inhibit, 32'h1);
    // direction contact stays off under position control
    apb(1'b1, svcil_pkg::OFS_CTRL, 32'h1);
    drive(12'h864);
    for (int f = 0; f < 3; f++) begin
      apb(1'b1, svcil_pkg::OFS_CTRL, 32'(f * 16 + 1));
      fmt <= 2'(f);
      dir <= (f == 1);
      go <= 1'b1;
      repeat (2) @(posedge pclk);
      go <= 1'b0;
      for (int n = 0; busy !== 1'b0; n++) begin
        if (n > 100) begin
          fail_count++;
          finish_test;
        end
        @(posedge pclk);
      end
      hold(4);
      check(perr, f == 1 ? 32'h0 : 32'h4);
    end
    drive(12'h860);
    check(cmd.ext_alarm, 32'h1);
    @(posedge pclk);
    zs <= 1'b1;
    hold(4);
    check(cmd.drive_on, 32'h0);
    drive(12'h064);
    drive(12'h06C);
    check(cmd.ext_alarm, 32'h0);
    check(perr, 32'h0);
    finish_test;
  end
endmodule : svcil_top_tb
`default_nettype wire
